// File: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin nChecks++; if ((g) !== (e)) begin errorCnt++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb;
	import sbefu_pkg::*;
	logic            mclk = 1'b0;
	logic            reset_n = 1'b0;
	logic [AW-1:0]   s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [DW-1:0]   s_axi_wdata = 32'h0, s_axi_rdata, rdat;
	logic [3:0]      s_axi_wstrb = 4'h0;
	logic            s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic            s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic            s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]      s_axi_bresp, s_axi_rresp, resp;
	logic            gpIrqA = 1'b0, gpIrqB = 1'b0, rxFifoPending = 1'b0, physRespBusy = 1'b0;
	logic            tardyAckSent = 1'b0, phyByteValid = 1'b0, cycleStartTxBegin = 1'b0;
	logic            subactionGapEnd = 1'b0, cycleStartSent = 1'b0, cycleStartRcvd = 1'b0;
	logic            arbResetGap = 1'b0, cycleMasterOn, irq;
	logic [7:0]      phyByte = 8'h00;
	logic [DW-1:0]   rxCycleTime = 32'h0, localCycleTime = 32'h0;
	logic [N_CTX-1:0] ctxDead = 4'h0, ctxEventBlock;
	int              errorCnt = 0;
	int              nChecks = 0;

	sbefu_top uut (.mclk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .gpIrqA, .gpIrqB, .rxFifoPending, .physRespBusy, .tardyAckSent, .phyByteValid,
		.phyByte, .cycleStartTxBegin, .subactionGapEnd, .cycleStartSent, .cycleStartRcvd, .rxCycleTime,
		.localCycleTime, .arbResetGap, .ctxDead, .ctxEventBlock, .cycleMasterOn, .irq);

	always #20 mclk = ~mclk;

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick

	// Starts one edge late so a back-to-back call never retouches bready in the same step
	// Waits for the answer however long it takes; only the watchdog ends a hang
	task automatic axw(input logic [AW-1:0] a, input logic [DW-1:0] d, input logic [3:0] s = 4'hF);
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axw

	task automatic axr(input logic [AW-1:0] a);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rdat = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axr

	task automatic rdChk(input string nm, input logic [AW-1:0] a, input logic [DW-1:0] e);
		axr(a);
		`CHK(nm, e, rdat)
	endtask : rdChk

	task automatic clrAll;
		axw(OFS_EVT_CLR, 32'hFFFF_FFFF);
	endtask : clrAll

	task automatic t_regs;
		rdChk("evtRst", OFS_EVT_SET, 32'h0);
		`CHK("irqRst", 1'b0, irq)
		axw(OFS_EVT_SET, 32'hFFFF_FFFF);
		rdChk("evtAll", OFS_EVT_SET, EVT_IMPL);
		rdChk("maskedNone", OFS_EVT_CLR, 32'h0);
		axw(OFS_MSK_SET, 32'h2000_0000);
		rdChk("mask", OFS_MSK_SET, 32'h2000_0000);
		rdChk("maskedSw", OFS_EVT_CLR, 32'h2000_0000);
		tick(2);
		`CHK("irqOn", 1'b1, irq)
		// Top byte lane disabled: only bits 23 to 20 clear
		axw(OFS_EVT_CLR, 32'hFFFF_FFFF, 4'h7);
		rdChk("clrStrb", OFS_EVT_SET, 32'h6F00_0000);
		clrAll();
		rdChk("clrAll", OFS_EVT_SET, 32'h0);
		tick(2);
		`CHK("irqOff", 1'b0, irq)
		axw(OFS_MSK_CLR, 32'hFFFF_FFFF);
		rdChk("maskClr", OFS_MSK_CLR, 32'h0);
		axw(OFS_EVT_SET, 32'h9000_0000);
		rdChk("rsvd", OFS_EVT_SET, 32'h0);
		axw(8'h10, 32'h1);
		`CHK("bresp", RESP_SLVERR, resp)
		axr(8'h10);
		`CHK("rresp", RESP_SLVERR, resp)
		`CHK("rdata", 32'h0, rdat)
	endtask : t_regs

	task automatic t_gp;
		axw(OFS_GP_CTRL, 32'h0080_0000);
		gpIrqB <= 1'b1;
		tick(3);
		rdChk("gpOff", OFS_EVT_SET, 32'h0);
		gpIrqA <= 1'b1;
		tick(1);
		gpIrqA <= 1'b0;
		gpIrqB <= 1'b0;
		tick(2);
		rdChk("gpA", OFS_EVT_SET, 32'h1 << BIT_GP);
		clrAll();
		axw(OFS_GP_CTRL, 32'h8000_0000);
		rdChk("gpCtrl", OFS_GP_CTRL, 32'h8000_0000);
		gpIrqB <= 1'b1;
		tick(3);
		gpIrqB <= 1'b0;
		rdChk("gpB", OFS_EVT_SET, 32'h1 << BIT_GP);
		clrAll();
	endtask : t_gp

	task automatic t_late;
		int i;
		rxFifoPending <= 1'b1;
		tick(3);
		rxFifoPending <= 1'b0;
		rdChk("lateOff", OFS_EVT_SET, 32'h0);
		axw(OFS_HC_CTRL, 32'h2000_0000);
		rdChk("hcEn", OFS_HC_CTRL, 32'h2000_0000);
		for (i = 0; i < 3; i++) begin
			{tardyAckSent, physRespBusy, rxFifoPending} <= 3'h1 << i;
			tick(2);
			{tardyAckSent, physRespBusy, rxFifoPending} <= 3'h0;
			rdChk("lateOn", OFS_EVT_SET, 32'h1 << BIT_LATE);
			clrAll();
		end
	endtask : t_late

	task automatic t_phy;
		phyByte <= 8'hA5;
		phyByteValid <= 1'b1;
		tick(1);
		phyByteValid <= 1'b0;
		tick(2);
		rdChk("phyEvt", OFS_EVT_SET, 32'h1 << BIT_PHY);
		axr(OFS_PHY_CTRL);
		`CHK("phyReg", 8'hA5, rdat[23:16])
		clrAll();
	endtask : t_phy

	// Gap closed at 3000 cycles must not trip; an open one must by 3126
	task automatic t_overrun;
		axw(OFS_LINK_CTRL, 32'h0020_0000);
		`CHK("master", 1'b1, cycleMasterOn)
		rdChk("linkOn", OFS_LINK_CTRL, 32'h0020_0000);
		cycleStartTxBegin <= 1'b1;
		tick(1);
		cycleStartTxBegin <= 1'b0;
		tick(3000);
		subactionGapEnd <= 1'b1;
		tick(1);
		subactionGapEnd <= 1'b0;
		tick(200);
		rdChk("noOvr", OFS_EVT_SET, 32'h0);
		cycleStartTxBegin <= 1'b1;
		tick(1);
		cycleStartTxBegin <= 1'b0;
		tick(3100);
		`CHK("masterHeld", 1'b1, cycleMasterOn)
		tick(40);
		`CHK("masterOff", 1'b0, cycleMasterOn)
		rdChk("ovr", OFS_EVT_SET, 32'h1 << BIT_OVR);
		rdChk("linkOff", OFS_LINK_CTRL, 32'h0);
		clrAll();
	endtask : t_overrun

	task automatic t_fatal;
		ctxDead <= 4'h4;
		tick(3);
		`CHK("block", 4'h4, ctxEventBlock)
		ctxDead <= 4'h0;
		rdChk("fatal", OFS_EVT_SET, 32'h1 << BIT_FATAL);
		`CHK("blockKept", 4'h4, ctxEventBlock)
		clrAll();
		tick(2);
		`CHK("blockOff", 4'h0, ctxEventBlock)
	endtask : t_fatal

	task automatic t_cycle;
		cycleStartRcvd <= 1'b1;
		tick(1);
		cycleStartRcvd <= 1'b0;
		rdChk("sameTime", OFS_EVT_SET, 32'h0);
		rxCycleTime <= 32'h0000_1000;
		cycleStartRcvd <= 1'b1;
		tick(1);
		cycleStartRcvd <= 1'b0;
		rdChk("mism", OFS_EVT_SET, 32'h1 << BIT_MISM);
		clrAll();
		localCycleTime <= 32'h0000_1000;
		rdChk("tick1", OFS_EVT_SET, 32'h1 << BIT_TICK);
		clrAll();
		cycleStartSent <= 1'b1;
		tick(1);
		cycleStartSent <= 1'b0;
		localCycleTime <= 32'h0000_0000;
		rdChk("tick2", OFS_EVT_SET, 32'h1 << BIT_TICK);
		clrAll();
		localCycleTime <= 32'h0000_1000;
		rdChk("lost", OFS_EVT_SET, (32'h1 << BIT_TICK) | (32'h1 << BIT_LOST));
		clrAll();
		arbResetGap <= 1'b1;
		tick(1);
		arbResetGap <= 1'b0;
		rdChk("lostEarly", OFS_EVT_SET, 32'h1 << BIT_LOST);
		clrAll();
		localCycleTime <= 32'h8000_1000;
		rdChk("roll", OFS_EVT_SET, 32'h1 << BIT_ROLL);
		rdChk("timer", OFS_CYC_TIMER, 32'h8000_1000);
		clrAll();
	endtask : t_cycle

	task automatic end_of_test;
		if (errorCnt == 0 && nChecks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_of_test

	// Longest scenario is the overrun pair at about 6500 cycles
	initial begin
		repeat (30000) @(posedge mclk);
		errorCnt++;
		end_of_test();
	end

	initial begin
		repeat (12) @(posedge mclk);
		reset_n <= 1'b1;
		tick(1);
		t_regs();
		t_gp();
		t_late();
		t_phy();
		t_overrun();
		t_fatal();
		t_cycle();
		end_of_test();
	end
endmodule : tb
`default_nettype wire

// File: verilog/sbefu_flag.sv
`timescale 1ns/1ps
`default_nettype none
module sbefu_flag #(
	parameter bit USE_EDGE = 1'b1
) (
	input  wire logic mclk,
	input  wire logic reset_n,
	input  wire logic src,
	input  wire logic swSet,
	input  wire logic swClr,
	output logic      flag
);
	import sbefu_pkg::*;

	logic srcPrev_ff;
	logic flag_ff;

	wire hwSet    = USE_EDGE ? (src & ~srcPrev_ff) : src;
	// Set beats a clear landing in the same cycle
	wire nxt_flag = hwSet | swSet | (flag_ff & ~swClr);

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			srcPrev_ff <= RST_BIT;
			flag_ff    <= RST_BIT;
		end else begin
			srcPrev_ff <= src;
			flag_ff    <= nxt_flag;
		end
	end

	assign flag = flag_ff;

	set_wins_a: assert property (@(posedge mclk) disable iff (!reset_n)
		(hwSet || swSet) |=> flag_ff) else $error("flag missed a set");
	clr_only_a: assert property (@(posedge mclk) disable iff (!reset_n)
		(swClr && !hwSet && !swSet) |=> !flag_ff) else $error("flag survived a clear");
	hold_flag_a: assert property (@(posedge mclk) disable iff (!reset_n)
		(flag_ff && !swClr) |=> flag_ff) else $error("flag dropped without a clear");
endmodule : sbefu_flag
`default_nettype wire

// File: verilog/sbefu_overrun_timer.sv
`timescale 1ns/1ps
`default_nettype none
module sbefu_overrun_timer (
	input  wire logic mclk,
	input  wire logic reset_n,
	input  wire logic masterOn,
	input  wire logic txStart,
	input  wire logic gapEnd,
	output logic      overrun
);
	import sbefu_pkg::*;

	logic [TMR_W-1:0] cnt_ff;
	logic             run_ff;
	logic             ovr_ff;

	wire atLimit = cnt_ff == TMR_W'(CYC_LIMIT_CYC);
	// Limit reached and the gap still not over: strictly more than the period
	wire nxt_ovr = masterOn & run_ff & ~txStart & ~gapEnd & atLimit;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_ff <= '0;
			run_ff <= RST_BIT;
			ovr_ff <= RST_BIT;
		end else begin
			ovr_ff <= nxt_ovr;
			if (!masterOn || nxt_ovr) begin
				run_ff <= 1'b0;
			end else if (txStart) begin
				run_ff <= 1'b1;
				cnt_ff <= '0;
			end else if (gapEnd) begin
				run_ff <= 1'b0;
			end else if (run_ff) begin
				cnt_ff <= cnt_ff + 1'b1;
			end
		end
	end

	assign overrun = ovr_ff;

	ovr_cause_a: assert property (@(posedge mclk) disable iff (!reset_n)
		ovr_ff |-> $past(cnt_ff) == TMR_W'(CYC_LIMIT_CYC) && $past(masterOn) && !$past(gapEnd))
		else $error("overrun without full period");
	cnt_bound_a: assert property (@(posedge mclk) disable iff (!reset_n)
		cnt_ff <= TMR_W'(CYC_LIMIT_CYC)) else $error("cycle timer ran past its limit");
endmodule : sbefu_overrun_timer
`default_nettype wire

// File: verilog/sbefu_pkg.sv
`default_nettype none
package sbefu_pkg;
	localparam int AW = 8;
	localparam int DW = 32;
	localparam int N_CTX = 4;
	localparam int TMR_W = 12;

	localparam logic [AW-1:0] OFS_HC_CTRL   = 8'h50;
	localparam logic [AW-1:0] OFS_EVT_SET   = 8'h80;
	localparam logic [AW-1:0] OFS_EVT_CLR   = 8'h84;
	localparam logic [AW-1:0] OFS_MSK_SET   = 8'h88;
	localparam logic [AW-1:0] OFS_MSK_CLR   = 8'h8C;
	localparam logic [AW-1:0] OFS_LINK_CTRL = 8'hE0;
	localparam logic [AW-1:0] OFS_PHY_CTRL  = 8'hEC;
	localparam logic [AW-1:0] OFS_CYC_TIMER = 8'hF0;
	localparam logic [AW-1:0] OFS_GP_CTRL   = 8'hFC;

	localparam int BIT_GP    = 30;
	localparam int BIT_SW    = 29;
	localparam int BIT_LATE  = 27;
	localparam int BIT_PHY   = 26;
	localparam int BIT_OVR   = 25;
	localparam int BIT_FATAL = 24;
	localparam int BIT_MISM  = 23;
	localparam int BIT_LOST  = 22;
	localparam int BIT_ROLL  = 21;
	localparam int BIT_TICK  = 20;

	localparam logic [DW-1:0] EVT_IMPL  = 32'h6FF0_0000;
	localparam logic [DW-1:0] EDGE_BITS = 32'h4D00_0000;

	localparam int BIT_LATE_EN = 29;
	localparam int BIT_MASTER  = 21;
	localparam int BIT_GPB_EN  = 31;
	localparam int BIT_GPA_EN  = 23;
	localparam int PHY_LO      = 16;
	localparam int SEC_HI      = 31;
	localparam int CNT_LO      = 12;

	localparam logic          RST_BIT   = 1'b0;
	localparam logic          RST_READY = 1'b1;
	localparam logic [DW-1:0] RST_WORD  = 32'h0000_0000;
	localparam logic [1:0]    RESP_OKAY   = 2'h0;
	localparam logic [1:0]    RESP_SLVERR = 2'h2;

	localparam int CYC_LIMIT_NS  = 125000;
	localparam int CLK_NS        = 40;
	localparam int CYC_LIMIT_CYC = (CYC_LIMIT_NS + CLK_NS - 1) / CLK_NS;
endpackage : sbefu_pkg
`default_nettype wire

// File: verilog/sbefu_top.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Event bits 31 and 28 always read zero; writes to them do nothing.
// - Bit 30 sets when an enabled general-purpose interrupt input rises.
// - Bit 29 is software-only, changed solely by set and clear writes.
// - With late-ack enable, bit 27 sets on FIFO data, busy responder or tardy ack.
// - Bit 26 sets on a PHY register byte, readable in PHY control bits 23-16.
// - While cycle master, bit 25 sets if a cycle exceeds 125 us.
// - A cycle overrun clears the cycle master bit automatically.
// - Bit 24 sets on any error halting a subunit, e.g. dead DMA context.
// - While bit 24 is set, offending contexts have normal events blocked.
// - Bit 23 sets when received cycle start time differs from local timer.
// - Bit 22 sets when no cycle start occurs between two cycle ticks.
// - Bit 22 may set early when arbitration reset gap follows tick without start.
// - Bit 21 sets whenever the seventh seconds bit changes.
// - Bit 20 sets whenever the cycle count low bit toggles.
// - Bits 30, 27, 26 and 24 set on source rise, the others while their source is high, or on a set write; only a clear write clears them.
// - Reading the clear port returns event bits ANDed with the mask.
module sbefu_top (
	input  wire logic                    mclk,
	input  wire logic                    reset_n,
	input  wire logic [sbefu_pkg::AW-1:0] s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [sbefu_pkg::DW-1:0] s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [sbefu_pkg::AW-1:0] s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [sbefu_pkg::DW-1:0]     s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	input  wire logic                    gpIrqA,
	input  wire logic                    gpIrqB,
	input  wire logic                    rxFifoPending,
	input  wire logic                    physRespBusy,
	input  wire logic                    tardyAckSent,
	input  wire logic                    phyByteValid,
	input  wire logic [7:0]              phyByte,
	input  wire logic                    cycleStartTxBegin,
	input  wire logic                    subactionGapEnd,
	input  wire logic                    cycleStartSent,
	input  wire logic                    cycleStartRcvd,
	input  wire logic [sbefu_pkg::DW-1:0] rxCycleTime,
	input  wire logic [sbefu_pkg::DW-1:0] localCycleTime,
	input  wire logic                    arbResetGap,
	input  wire logic [sbefu_pkg::N_CTX-1:0] ctxDead,
	output logic [sbefu_pkg::N_CTX-1:0]  ctxEventBlock,
	output logic                         cycleMasterOn,
	output logic                         irq
);
	import sbefu_pkg::*;

	logic             awReady_ff, wReady_ff, bValid_ff, awHeld_ff, wHeld_ff;
	logic [AW-1:0]    awAddr_ff;
	logic [DW-1:0]    wData_ff;
	logic [3:0]       wStrb_ff;
	logic [1:0]       bResp_ff;
	logic             arReady_ff, rValid_ff;
	logic [DW-1:0]    rData_ff;
	logic [1:0]       rResp_ff;
	logic [DW-1:0]    mask_ff;
	logic             lateAckEn_ff, master_ff, gpAEn_ff, gpBEn_ff;
	logic [7:0]       phyData_ff;
	logic             secB6Prev_ff, cntLsbPrev_ff;
	logic             sawStart_ff, armed_ff, afterTick_ff;
	logic [N_CTX-1:0] offendCtx_ff, ctxBlock_ff;
	logic             irq_ff;
	wire  [DW-1:0]    evtFlags;
	wire  [DW-1:0]    srcVec;
	wire              ovrPulse;

	// Write channel: address and data may arrive in either order
	wire awTake = s_axi_awvalid & awReady_ff;
	wire wTake  = s_axi_wvalid & wReady_ff;
	wire wrFire = awHeld_ff & wHeld_ff & ~bValid_ff;
	wire bDone  = bValid_ff & s_axi_bready;

	wire wSelSet  = awAddr_ff == OFS_EVT_SET;
	wire wSelClr  = awAddr_ff == OFS_EVT_CLR;
	wire wSelMSet = awAddr_ff == OFS_MSK_SET;
	wire wSelMClr = awAddr_ff == OFS_MSK_CLR;
	wire wSelHc   = awAddr_ff == OFS_HC_CTRL;
	wire wSelLink = awAddr_ff == OFS_LINK_CTRL;
	wire wSelGp   = awAddr_ff == OFS_GP_CTRL;
	// Read-only words accept writes silently
	wire wrHit = wSelSet | wSelClr | wSelMSet | wSelMClr | wSelHc | wSelLink | wSelGp
		| (awAddr_ff == OFS_PHY_CTRL) | (awAddr_ff == OFS_CYC_TIMER);

	wire [DW-1:0] wMask = {{8{wStrb_ff[3]}}, {8{wStrb_ff[2]}}, {8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}};
	wire [DW-1:0] wVal  = wData_ff & wMask;
	wire [DW-1:0] swSet = {DW{wrFire & wSelSet}} & wVal & EVT_IMPL;
	wire [DW-1:0] swClr = {DW{wrFire & wSelClr}} & wVal & EVT_IMPL;
	wire [DW-1:0] mSet  = {DW{wrFire & wSelMSet}} & wVal & EVT_IMPL;
	wire [DW-1:0] mClr  = {DW{wrFire & wSelMClr}} & wVal & EVT_IMPL;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			awReady_ff <= RST_READY;
			wReady_ff  <= RST_READY;
			awHeld_ff  <= RST_BIT;
			wHeld_ff   <= RST_BIT;
			bValid_ff  <= RST_BIT;
			bResp_ff   <= RESP_OKAY;
			awAddr_ff  <= '0;
			wData_ff   <= RST_WORD;
			wStrb_ff   <= '0;
		end else begin
			awReady_ff <= bDone | (awReady_ff & ~awTake);
			wReady_ff  <= bDone | (wReady_ff & ~wTake);
			awHeld_ff  <= awTake | (awHeld_ff & ~wrFire);
			wHeld_ff   <= wTake | (wHeld_ff & ~wrFire);
			bValid_ff  <= wrFire | (bValid_ff & ~bDone);
			if (wrFire)
				bResp_ff <= wrHit ? RESP_OKAY : RESP_SLVERR;
			if (awTake)
				awAddr_ff <= s_axi_awaddr;
			if (wTake) begin
				wData_ff <= s_axi_wdata;
				wStrb_ff <= s_axi_wstrb;
			end
		end
	end

	// Control words
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			mask_ff      <= RST_WORD;
			lateAckEn_ff <= RST_BIT;
			master_ff    <= RST_BIT;
			gpAEn_ff     <= RST_BIT;
			gpBEn_ff     <= RST_BIT;
			phyData_ff   <= '0;
		end else begin
			mask_ff <= (mask_ff | mSet) & ~mClr;
			if (wrFire && wSelHc && wMask[BIT_LATE_EN])
				lateAckEn_ff <= wData_ff[BIT_LATE_EN];
			// Hardware clear outranks a simultaneous software write
			if (ovrPulse)
				master_ff <= 1'b0;
			else if (wrFire && wSelLink && wMask[BIT_MASTER])
				master_ff <= wData_ff[BIT_MASTER];
			if (wrFire && wSelGp && wMask[BIT_GPA_EN])
				gpAEn_ff <= wData_ff[BIT_GPA_EN];
			if (wrFire && wSelGp && wMask[BIT_GPB_EN])
				gpBEn_ff <= wData_ff[BIT_GPB_EN];
			if (phyByteValid)
				phyData_ff <= phyByte;
		end
	end

	// Read channel
	wire arTake = s_axi_arvalid & arReady_ff;
	wire rDone  = rValid_ff & s_axi_rready;

	wire rSelSet  = s_axi_araddr == OFS_EVT_SET;
	wire rSelClr  = s_axi_araddr == OFS_EVT_CLR;
	wire rSelMask = (s_axi_araddr == OFS_MSK_SET) | (s_axi_araddr == OFS_MSK_CLR);
	wire rSelHc   = s_axi_araddr == OFS_HC_CTRL;
	wire rSelLink = s_axi_araddr == OFS_LINK_CTRL;
	wire rSelPhy  = s_axi_araddr == OFS_PHY_CTRL;
	wire rSelTime = s_axi_araddr == OFS_CYC_TIMER;
	wire rSelGp   = s_axi_araddr == OFS_GP_CTRL;
	wire rdHit = rSelSet | rSelClr | rSelMask | rSelHc | rSelLink | rSelPhy | rSelTime | rSelGp;

	wire [DW-1:0] hcWord   = DW'(lateAckEn_ff) << BIT_LATE_EN;
	wire [DW-1:0] linkWord = DW'(master_ff) << BIT_MASTER;
	wire [DW-1:0] phyWord  = DW'(phyData_ff) << PHY_LO;
	wire [DW-1:0] gpWord   = (DW'(gpBEn_ff) << BIT_GPB_EN) | (DW'(gpAEn_ff) << BIT_GPA_EN);
	wire [DW-1:0] rdMux =
		rSelSet  ? evtFlags :
		rSelClr  ? (evtFlags & mask_ff) :
		rSelMask ? mask_ff :
		rSelHc   ? hcWord :
		rSelLink ? linkWord :
		rSelPhy  ? phyWord :
		rSelTime ? localCycleTime :
		rSelGp   ? gpWord : RST_WORD;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			arReady_ff <= RST_READY;
			rValid_ff  <= RST_BIT;
			rData_ff   <= RST_WORD;
			rResp_ff   <= RESP_OKAY;
		end else begin
			arReady_ff <= rDone | (arReady_ff & ~arTake);
			rValid_ff  <= arTake | (rValid_ff & ~rDone);
			if (arTake) begin
				rData_ff <= rdMux;
				rResp_ff <= rdHit ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// Event sources
	wire gpSrc     = (gpIrqA & gpAEn_ff) | (gpIrqB & gpBEn_ff);
	wire lateSrc   = lateAckEn_ff & (rxFifoPending | physRespBusy | tardyAckSent);
	wire fatalSrc  = |ctxDead;
	wire timeDiff  = rxCycleTime[SEC_HI:CNT_LO] != localCycleTime[SEC_HI:CNT_LO];
	wire mismPulse = cycleStartRcvd & timeDiff;
	wire rollPulse = localCycleTime[SEC_HI] ^ secB6Prev_ff;
	wire tickPulse = localCycleTime[CNT_LO] ^ cntLsbPrev_ff;
	wire cycStart  = cycleStartSent | cycleStartRcvd;
	// A start in the tick cycle belongs to the new period
	wire lostPulse = tickPulse & armed_ff & ~sawStart_ff;
	wire predPulse = afterTick_ff & arbResetGap & ~cycStart;
	wire lostSrc   = lostPulse | predPulse;

	assign srcVec = {1'b0, gpSrc, 1'b0, 1'b0, lateSrc, phyByteValid, ovrPulse, fatalSrc,
		mismPulse, lostSrc, rollPulse, tickPulse, 20'h0_0000};

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			secB6Prev_ff  <= RST_BIT;
			cntLsbPrev_ff <= RST_BIT;
			sawStart_ff   <= RST_BIT;
			armed_ff      <= RST_BIT;
			afterTick_ff  <= RST_BIT;
		end else begin
			secB6Prev_ff  <= localCycleTime[SEC_HI];
			cntLsbPrev_ff <= localCycleTime[CNT_LO];
			sawStart_ff   <= cycStart | (sawStart_ff & ~tickPulse);
			armed_ff      <= armed_ff | tickPulse;
			afterTick_ff  <= tickPulse | (afterTick_ff & ~cycStart & ~arbResetGap);
		end
	end

	sbefu_overrun_timer uOverrun (
		.mclk     (mclk),
		.reset_n  (reset_n),
		.masterOn (master_ff),
		.txStart  (cycleStartTxBegin),
		.gapEnd   (subactionGapEnd),
		.overrun  (ovrPulse)
	);

	genvar gi;
	generate
		for (gi = 0; gi < DW; gi++) begin : gFlag
			if (EVT_IMPL[gi]) begin : gOn
				sbefu_flag #(.USE_EDGE(EDGE_BITS[gi])) uFlag (
					.mclk    (mclk),
					.reset_n (reset_n),
					.src     (srcVec[gi]),
					.swSet   (swSet[gi]),
					.swClr   (swClr[gi]),
					.flag    (evtFlags[gi])
				);
			end else begin : gOff
				assign evtFlags[gi] = 1'b0;
			end
		end
	endgenerate

	// Offenders stay recorded until software clears the fatal flag
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			offendCtx_ff <= '0;
			ctxBlock_ff  <= '0;
			irq_ff       <= RST_BIT;
		end else begin
			offendCtx_ff <= evtFlags[BIT_FATAL] ? (offendCtx_ff | ctxDead) : ctxDead;
			ctxBlock_ff  <= {N_CTX{evtFlags[BIT_FATAL]}} & (offendCtx_ff | ctxDead);
			irq_ff       <= |(evtFlags & mask_ff);
		end
	end

	assign s_axi_awready = awReady_ff;
	assign s_axi_wready  = wReady_ff;
	assign s_axi_bvalid  = bValid_ff;
	assign s_axi_bresp   = bResp_ff;
	assign s_axi_arready = arReady_ff;
	assign s_axi_rvalid  = rValid_ff;
	assign s_axi_rdata   = rData_ff;
	assign s_axi_rresp   = rResp_ff;
	assign ctxEventBlock = ctxBlock_ff;
	assign cycleMasterOn = master_ff;
	assign irq           = irq_ff;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	wire [DW-1:0] maskedEvt = evtFlags & mask_ff;
	wire          anyPend   = |maskedEvt;

	sequence evtRead;
		arTake && (rSelSet || rSelClr);
	endsequence
	sequence clrRead;
		arTake && rSelClr;
	endsequence

	rsvd_zero_a: assert property (evtRead |=> !s_axi_rdata[31] && !s_axi_rdata[28])
		else $error("reserved event bit read nonzero");
	gp_event_a: assert property ($rose(gpSrc) |=> evtFlags[BIT_GP])
		else $error("gp event not latched");
	soft_only_a: assert property ($rose(evtFlags[BIT_SW]) |-> $past(swSet[BIT_SW]))
		else $error("software flag set by hardware");
	late_ack_a: assert property ($rose(lateSrc) |=> evtFlags[BIT_LATE])
		else $error("late ack event missed");
	// Edge-set flag: a held valid may see its flag cleared meanwhile
	phy_byte_a: assert property ($rose(phyByteValid) |=> evtFlags[BIT_PHY])
		else $error("phy byte event missed");
	phy_data_a: assert property (phyByteValid |=> phyData_ff == $past(phyByte))
		else $error("phy byte not captured");
	overrun_a: assert property (ovrPulse |=> evtFlags[BIT_OVR] && !master_ff)
		else $error("overrun did not flag and drop master");
	fatal_a: assert property ($rose(fatalSrc) |=> evtFlags[BIT_FATAL])
		else $error("fatal error not latched");
	ctx_block_a: assert property (evtFlags[BIT_FATAL] && ctxDead != '0 |=> (ctxBlock_ff & $past(ctxDead)) == $past(ctxDead))
		else $error("offending context not blocked");
	mismatch_a: assert property (cycleStartRcvd && timeDiff |=> evtFlags[BIT_MISM])
		else $error("cycle mismatch missed");
	lost_a: assert property (tickPulse && armed_ff && !sawStart_ff |=> evtFlags[BIT_LOST])
		else $error("lost cycle missed");
	predict_a: assert property (afterTick_ff && arbResetGap && !cycStart |=> evtFlags[BIT_LOST])
		else $error("predicted lost cycle missed");
	rollover_a: assert property ($changed(localCycleTime[SEC_HI]) |=> evtFlags[BIT_ROLL])
		else $error("seconds rollover missed");
	tick_a: assert property ($changed(localCycleTime[CNT_LO]) |=> evtFlags[BIT_TICK])
		else $error("cycle tick missed");
	sw_clear_a: assert property (swClr[BIT_SW] && !swSet[BIT_SW] |=> !evtFlags[BIT_SW])
		else $error("software clear ignored");
	masked_read_a: assert property (clrRead |=> s_axi_rdata == $past(maskedEvt))
		else $error("clear port read not masked");
	irq_level_a: assert property (irq == $past(anyPend))
		else $error("interrupt output wrong");
endmodule : sbefu_top
`default_nettype wire
